// file: logic/msp_ctrl.sv
// MAC-side serial PCS control and status registers with preamble insertion.
`timescale 1ns/1ps
module msp_ctrl
   import msp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic soft_rst_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // PCS side.
   input wire logic media_link_i,
   input wire msp_pcs_stat_t pcs_stat_i,
   input wire logic [15:0] int_adv_word_i,
   output logic mac_if_disable_o,
   output logic mac_if_restart_o,
   output logic parallel_detection_o,
   output logic link_negotiation_restart_o,
   output logic link_negotiation_en_o,
   output logic rx_invert_o,
   output logic tx_invert_o,
   output logic [15:0] adv_word_o,
   // 10/100 byte stream toward the MAC.
   input wire logic in_valid_i,
   input wire msp_beat_t in_beat_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output msp_beat_t out_beat_o,
   input wire logic out_ready_i
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [15:0] page_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] adv_reg;
   logic lp_rst_reg;
   msp_pcs_stat_t stat_reg;

   wire [5:0] idx = wb_adr_i[7:2];
   wire req = wb_cyc_i & wb_stb_i;
   wire wr_go = req & wb_we_i & wb_ack_o;
   wire ext_pg = (page_reg == MSP_PAGE_EXT);
   wire hit_ctrl = ext_pg & (idx == MSP_IDX_CTRL);
   wire hit_stat = ext_pg & (idx == MSP_IDX_STAT);
   wire hit_adv = ext_pg & (idx == MSP_IDX_ADV);
   wire hit_page = (idx == MSP_IDX_PAGE);
   wire rd_stat = req & ~wb_we_i & hit_stat & ~wb_ack_o;
   wire forced = ctrl_reg[MSP_C_FORCE];

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   wire [15:0] ctrl_w = merge(ctrl_reg, wb_dat_i, wb_sel_i);
   wire [15:0] adv_rd = forced ? adv_reg : int_adv_word_i;

   wire [15:0] stat_rd = {4'h0, lp_rst_reg, 1'b0,
                          stat_reg.remote_fault,
                          stat_reg.asym_pause, stat_reg.sym_pause,
                          stat_reg.full_duplex,
                          stat_reg.half_duplex,
                          stat_reg.lp_link_negotiation_capable,
                          stat_reg.link_up,
                          stat_reg.link_negotiation_complete,
                          stat_reg.signal_detect};

   wire [15:0] rd_mux = hit_page ? page_reg :
                        hit_ctrl ? {ctrl_reg[15:13], 1'b0, ctrl_reg[11:5],
                                    5'h00} :
                        hit_stat ? stat_rd :
                        hit_adv ? adv_rd : 16'h0000;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o) begin
            wb_dat_o <= {16'h0000, rd_mux};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         page_reg <= MSP_PAGE_RST;
      end else if (wr_go & hit_page) begin
         page_reg <= merge(page_reg, wb_dat_i, wb_sel_i);
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic anrst_reg;
   wire ctrl_wr = wr_go & hit_ctrl;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= {3'h0, 1'b0, 1'b0, MSP_PRE_RST, 3'h0, 5'h00};
         anrst_reg <= 1'b0;
      end else begin
         anrst_reg <= ctrl_wr & ctrl_w[MSP_C_ANRST];
         if (ctrl_wr) begin
            ctrl_reg <= {ctrl_w[15:13], 1'b0, ctrl_w[11:5], 5'h00};
         end else if (soft_rst_i) begin
            // Sticky bits 15:13 are kept across a soft reset.
            ctrl_reg <= {ctrl_reg[15:13], 1'b0, 1'b0, MSP_PRE_RST,
                         3'h0, 5'h00};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         adv_reg <= MSP_ADV_RST;
      end else if (wr_go & hit_adv & forced) begin
         adv_reg <= merge(adv_reg, wb_dat_i, wb_sel_i);
      end else if (soft_rst_i) begin
         adv_reg <= MSP_ADV_RST;
      end
   end

   // ----------------------------------------------------------------
   // Status capture
   // ----------------------------------------------------------------
   // The partner restart flag holds until a status read; a new request
   // in the clearing cycle wins.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_reg <= '0;
         lp_rst_reg <= 1'b0;
      end else begin
         stat_reg <= pcs_stat_i;
         if (pcs_stat_i.lp_restart) begin
            lp_rst_reg <= 1'b1;
         end else if (rd_stat) begin
            lp_rst_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // PCS control outputs
   // ----------------------------------------------------------------
   logic media_prev_reg;
   wire media_chg = media_prev_reg ^ media_link_i;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         media_prev_reg <= 1'b0;
         mac_if_disable_o <= 1'b0;
         mac_if_restart_o <= 1'b0;
         parallel_detection_o <= 1'b0;
         link_negotiation_restart_o <= 1'b0;
         link_negotiation_en_o <= 1'b0;
         rx_invert_o <= 1'b0;
         tx_invert_o <= 1'b0;
         adv_word_o <= MSP_ADV_RST;
      end else begin
         media_prev_reg <= media_link_i;
         mac_if_disable_o <= ctrl_reg[MSP_C_DIS] & ~media_link_i;
         mac_if_restart_o <= ctrl_reg[MSP_C_RESTART] & media_chg;
         parallel_detection_o <= ctrl_reg[MSP_C_PD];
         link_negotiation_restart_o <= anrst_reg;
         link_negotiation_en_o <= ctrl_reg[MSP_C_ANEN];
         rx_invert_o <= ctrl_reg[MSP_C_RXINV];
         tx_invert_o <= ctrl_reg[MSP_C_TXINV];
         adv_word_o <= adv_rd;
      end
   end

   // ----------------------------------------------------------------
   // Preamble insertion
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MSP_S_PASS,
      MSP_S_GRAB,
      MSP_S_PRE,
      MSP_S_HOLD
   } msp_state_t;

   msp_state_t st_reg;
   msp_beat_t hold_reg [2];
   logic [1:0] hold_n_reg;
   logic hold_i_reg;
   logic [1:0] pre_reg;
   logic first_reg;
   logic inj_reg;

   wire [2:0] code = ctrl_reg[10:MSP_C_PRE_LO];
   wire act = (code == MSP_PRE_ONE) | (code == MSP_PRE_TWO);
   wire slot = ~out_valid_o | out_ready_i;
   wire b0_bad = (in_beat_i.data != MSP_PRE_BYTE);
   wire h0_bad = (hold_reg[0].data != MSP_PRE_BYTE);
   wire take = in_valid_i & in_ready_o;
   wire pass_take = take & (st_reg == MSP_S_PASS);
   wire start = pass_take & in_beat_i.sop & act;
   wire one_only = (code == MSP_PRE_ONE) | in_beat_i.eop;

   always_comb begin
      unique case (st_reg)
         MSP_S_PASS: in_ready_o = slot;
         MSP_S_GRAB: in_ready_o = 1'b1;
         default: in_ready_o = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= MSP_S_PASS;
         hold_reg[0] <= '0;
         hold_reg[1] <= '0;
         hold_n_reg <= 2'h0;
         hold_i_reg <= 1'b0;
         pre_reg <= 2'h0;
         first_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            MSP_S_PASS: begin
               if (start) begin
                  hold_reg[0] <= in_beat_i;
                  hold_n_reg <= 2'h1;
                  hold_i_reg <= 1'b0;
                  first_reg <= 1'b1;
                  pre_reg <= {1'b0, b0_bad};
                  st_reg <= one_only ? MSP_S_PRE : MSP_S_GRAB;
               end
            end
            MSP_S_GRAB: begin
               if (take) begin
                  hold_reg[1] <= in_beat_i;
                  hold_n_reg <= 2'h2;
                  pre_reg <= {h0_bad & b0_bad,
                              h0_bad & ~b0_bad};
                  st_reg <= MSP_S_PRE;
               end
            end
            MSP_S_PRE: begin
               if (pre_reg == 2'h0) begin
                  st_reg <= MSP_S_HOLD;
               end else if (slot) begin
                  pre_reg <= pre_reg - 2'h1;
                  first_reg <= 1'b0;
               end
            end
            MSP_S_HOLD: begin
               if (slot) begin
                  first_reg <= 1'b0;
                  hold_i_reg <= 1'b1;
                  if ({1'b0, hold_i_reg} == hold_n_reg - 2'h1) begin
                     st_reg <= MSP_S_PASS;
                  end
               end
            end
            default: st_reg <= MSP_S_PASS;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output beat register
   // ----------------------------------------------------------------
   msp_beat_t hb;
   assign hb = hold_reg[hold_i_reg];
   wire emit_pre = (st_reg == MSP_S_PRE) & (pre_reg != 2'h0) & slot;
   wire emit_hold = (st_reg == MSP_S_HOLD) & slot;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_valid_o <= 1'b0;
         out_beat_o <= '0;
         inj_reg <= 1'b0;
      end else if (slot) begin
         inj_reg <= emit_pre;
         if (emit_pre) begin
            out_valid_o <= 1'b1;
            out_beat_o <= '{sop: first_reg, eop: 1'b0,
                            data: MSP_PRE_BYTE};
         end else if (emit_hold) begin
            out_valid_o <= 1'b1;
            out_beat_o <= '{sop: first_reg, eop: hb.eop, data: hb.data};
         end else if (pass_take & ~start) begin
            out_valid_o <= 1'b1;
            out_beat_o <= in_beat_i;
         end else begin
            out_valid_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_disable_follows: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      mac_if_disable_o == $past(ctrl_reg[MSP_C_DIS] & ~media_link_i))
      else $error("interface disable does not track media link");

   chk_restart_on_change: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ctrl_reg[MSP_C_RESTART] && media_chg) |=> mac_if_restart_o)
      else $error("no restart after media link change");

   chk_pd_follows: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      ##1 parallel_detection_o == $past(ctrl_reg[MSP_C_PD]))
      else $error("parallel detection does not follow control");

   chk_anrst_pulse: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ctrl_wr && ctrl_w[MSP_C_ANRST]) |=> !ctrl_reg[MSP_C_ANRST]
      ##1 link_negotiation_restart_o ##1 !link_negotiation_restart_o)
      else $error("negotiation restart is not a single pulse");

   chk_adv_source: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      !forced ##1 !forced |-> adv_word_o == $past(int_adv_word_i))
      else $error("unforced advertised word not internal");

   chk_pass_plain: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (pass_take && !act && slot) |=> out_beat_o == $past(in_beat_i))
      else $error("passed beat altered without insertion");

   chk_one_prefix: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (start && code == MSP_PRE_ONE && b0_bad) |=> pre_reg == 2'h1)
      else $error("missing single preamble byte");

   chk_two_prefix: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (st_reg == MSP_S_GRAB && take && h0_bad && b0_bad)
      |=> pre_reg == 2'h2)
      else $error("missing second preamble byte");

   chk_pre_byte: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      inj_reg |-> out_valid_o && out_beat_o.data == MSP_PRE_BYTE)
      else $error("injected byte is not the preamble value");

   chk_lp_restart: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      pcs_stat_i.lp_restart |=> lp_rst_reg ##1 (lp_rst_reg || $past(rd_stat)))
      else $error("partner restart flag lost");

   chk_adv_lock: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (!forced && !soft_rst_i) |=> $stable(adv_reg))
      else $error("advertised word changed while not forced");

   chk_sticky_keep: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (soft_rst_i && !ctrl_wr) |=> ctrl_reg[15:13] == $past(ctrl_reg[15:13]))
      else $error("sticky bits lost on soft reset");

endmodule

// file: logic/msp_pkg.sv
// Package of offsets, fields, defaults and carriers for the PCS control.
package msp_pkg;

   // ----------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] MSP_IDX_CTRL = 6'h10;
   localparam logic [5:0] MSP_IDX_STAT = 6'h11;
   localparam logic [5:0] MSP_IDX_ADV = 6'h12;
   localparam logic [5:0] MSP_IDX_PAGE = 6'h1f;
   localparam logic [15:0] MSP_PAGE_EXT = 16'h0003;
   localparam logic [15:0] MSP_PAGE_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Control field positions and reset values
   // ----------------------------------------------------------------
   localparam int MSP_C_DIS = 15;
   localparam int MSP_C_RESTART = 14;
   localparam int MSP_C_PD = 13;
   localparam int MSP_C_ANRST = 12;
   localparam int MSP_C_FORCE = 11;
   localparam int MSP_C_PRE_LO = 8;
   localparam int MSP_C_ANEN = 7;
   localparam int MSP_C_RXINV = 6;
   localparam int MSP_C_TXINV = 5;
   localparam logic [2:0] MSP_PRE_NONE = 3'h0;
   localparam logic [2:0] MSP_PRE_ONE = 3'h1;
   localparam logic [2:0] MSP_PRE_TWO = 3'h2;
   localparam logic [2:0] MSP_PRE_RST = 3'h1;
   localparam logic [15:0] MSP_ADV_RST = 16'h0000;
   localparam logic [7:0] MSP_PRE_BYTE = 8'h55;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic lp_restart;
      logic [1:0] remote_fault;
      logic asym_pause;
      logic sym_pause;
      logic full_duplex;
      logic half_duplex;
      logic lp_link_negotiation_capable;
      logic link_up;
      logic link_negotiation_complete;
      logic signal_detect;
   } msp_pcs_stat_t;

   typedef struct packed {
      logic sop;
      logic eop;
      logic [7:0] data;
   } msp_beat_t;

endpackage

// file: bench/msp_mac_model.sv
// Far-side MAC model that takes the 10/100 byte stream.
`timescale 1ns/1ps
module msp_mac_model
   import msp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic stall_i,
   input wire logic out_valid_i,
   input wire msp_beat_t out_beat_i,
   output logic out_ready_o
);
   logic [1:0] cnt_reg;
   logic [8:0] got[$];
   // While stalling, the MAC refuses one beat slot in four.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= 2'h0;
         out_ready_o <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         out_ready_o <= !stall_i || (cnt_reg != 2'h3);
      end
   end
   always @(posedge clk_i) begin
      if (out_valid_i === 1'b1 && out_ready_o === 1'b1) begin
         got.push_back({out_beat_i.sop, out_beat_i.data});
      end
   end
endmodule

// file: bench/msp_ctrl_bench.sv
// Self-checking bench for the PCS control and status block.
`timescale 1ns/1ps
module msp_ctrl_bench
   import msp_pkg::*;
;
   localparam logic [15:0] ADV_INT = 16'h1234;
   logic clk_i, rst_b_i, soft_rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic wb_ack_o, media_link_i, in_valid_i, in_ready_o, out_valid_o;
   logic out_ready_i, stall;
   msp_pcs_stat_t pcs_stat_i;
   logic [15:0] int_adv_word_i, adv_word_o;
   logic mac_if_disable_o, mac_if_restart_o, parallel_detection_o;
   logic link_negotiation_restart_o, link_negotiation_en_o;
   logic rx_invert_o, tx_invert_o;
   msp_beat_t in_beat_i, out_beat_o;
   int miscompares = 0;
   int samples_checked = 0;
   int restarts = 0;
   int renegs = 0;

   msp_ctrl msp_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .soft_rst_i(soft_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .media_link_i(media_link_i), .pcs_stat_i(pcs_stat_i),
      .int_adv_word_i(int_adv_word_i), .mac_if_disable_o(mac_if_disable_o),
      .mac_if_restart_o(mac_if_restart_o),
      .parallel_detection_o(parallel_detection_o),
      .link_negotiation_restart_o(link_negotiation_restart_o),
      .link_negotiation_en_o(link_negotiation_en_o),
      .rx_invert_o(rx_invert_o), .tx_invert_o(tx_invert_o),
      .adv_word_o(adv_word_o), .in_valid_i(in_valid_i),
      .in_beat_i(in_beat_i), .in_ready_o(in_ready_o),
      .out_valid_o(out_valid_o), .out_beat_o(out_beat_o),
      .out_ready_i(out_ready_i));
   msp_mac_model msp_mac_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .stall_i(stall), .out_valid_i(out_valid_o), .out_beat_i(out_beat_o),
      .out_ready_o(out_ready_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      restarts <= restarts + (mac_if_restart_o === 1'b1);
      renegs <= renegs + (link_negotiation_restart_o === 1'b1);
   end

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic cmp_word(input string what, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_flag(input string what, input logic e, g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic wb(input logic we, input logic [5:0] idx,
         input logic [3:0] sel, input logic [15:0] wd,
         output logic [15:0] rd);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {idx, 2'b00, sel, 16'h0000, wd};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[15:0];
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [15:0] wd,
         input logic [3:0] sel = 4'h3);
      logic [15:0] d;
      wb(1'b1, idx, sel, wd, d);
   endtask
   task automatic rdc(input string what, input logic [5:0] idx,
         input logic [15:0] e);
      logic [15:0] d;
      wb(1'b0, idx, 4'h3, 16'h0000, d);
      cmp_word(what, e, d);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_page();
      rdc("ctrl unpaged", MSP_IDX_CTRL, 16'h0000);
      wr(MSP_IDX_PAGE, MSP_PAGE_EXT);
      rdc("ctrl reset", MSP_IDX_CTRL, 16'h0100);
      rdc("adv unforced", MSP_IDX_ADV, ADV_INT);
      rdc("unmapped", 6'h13, 16'h0000);
      cmp_word("adv out", ADV_INT, adv_word_o);
   endtask
   task automatic t_outs(input logic [15:0] v);
      wr(MSP_IDX_CTRL, v);
      repeat (2) @(posedge clk_i);
      cmp_flag("pd", v[13], parallel_detection_o);
      cmp_flag("an en", v[7], link_negotiation_en_o);
      cmp_flag("rx inv", v[6], rx_invert_o);
      cmp_flag("tx inv", v[5], tx_invert_o);
   endtask
   task automatic t_media(input logic [15:0] v);
      int r0;
      wr(MSP_IDX_CTRL, v);
      r0 = restarts;
      media_link_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      cmp_flag("disable", v[15], mac_if_disable_o);
      media_link_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      cmp_flag("disable up", 1'b0, mac_if_disable_o);
      cmp_word("restarts", v[14] ? 16'h2 : 16'h0, 16'(restarts - r0));
   endtask
   task automatic t_link_negotiation();
      int r0;
      r0 = renegs;
      wr(MSP_IDX_CTRL, 16'h1000);
      repeat (5) @(posedge clk_i);
      cmp_word("renegs", 16'h1, 16'(renegs - r0));
      rdc("ctrl selfclr", MSP_IDX_CTRL, 16'h0000);
   endtask
   task automatic t_adv();
      wr(MSP_IDX_CTRL, 16'h0900);
      rdc("adv reset", MSP_IDX_ADV, MSP_ADV_RST);
      wr(MSP_IDX_CTRL, 16'h0100);
      wr(MSP_IDX_ADV, 16'hbeef);
      rdc("adv ignored", MSP_IDX_ADV, ADV_INT);
      wr(MSP_IDX_CTRL, 16'h0900);
      wr(MSP_IDX_ADV, 16'hbeef);
      rdc("adv forced", MSP_IDX_ADV, 16'hbeef);
      wr(MSP_IDX_ADV, 16'h0011, 4'h1);
      rdc("adv lane", MSP_IDX_ADV, 16'hbe11);
      repeat (2) @(posedge clk_i);
      cmp_word("adv out", 16'hbe11, adv_word_o);
   endtask
   task automatic t_status();
      logic [10:0] p;
      for (int k = 0; k < 2; k++) begin
         p = k ? 11'h15a : 11'h2a5;
         pcs_stat_i <= p;
         repeat (3) @(posedge clk_i);
         rdc("status", MSP_IDX_STAT, 16'(p[9:0]));
      end
      pcs_stat_i <= {1'b1, p[9:0]};
      @(posedge clk_i);
      pcs_stat_i <= p;
      repeat (3) @(posedge clk_i);
      rdc("status lp", MSP_IDX_STAT, {6'h02, p[9:0]});
      rdc("status clr", MSP_IDX_STAT, {6'h00, p[9:0]});
   endtask
   task automatic t_soft();
      wr(MSP_IDX_CTRL, 16'he8e0);
      wr(MSP_IDX_ADV, 16'hbeef);
      @(posedge clk_i);
      soft_rst_i <= 1'b1;
      @(posedge clk_i);
      soft_rst_i <= 1'b0;
      wr(MSP_IDX_PAGE, MSP_PAGE_EXT);
      rdc("ctrl soft", MSP_IDX_CTRL, 16'he100);
      wr(MSP_IDX_CTRL, 16'h0900);
      rdc("adv soft", MSP_IDX_ADV, MSP_ADV_RST);
   endtask
   task automatic t_hard();
      wr(MSP_IDX_PAGE, MSP_PAGE_EXT);
      wr(MSP_IDX_CTRL, 16'he000);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      cmp_flag("pd hard", 1'b0, parallel_detection_o);
      wr(MSP_IDX_PAGE, MSP_PAGE_EXT);
      rdc("ctrl hard", MSP_IDX_CTRL, 16'h0100);
   endtask
   task automatic send3(input logic [23:0] b);
      for (int i = 0; i < 3; i++) begin
         in_valid_i <= 1'b1;
         in_beat_i <= '{sop: i == 0, eop: i == 2, data: b[23-8*i -: 8]};
         do @(posedge clk_i); while (in_ready_o !== 1'b1);
      end
      in_valid_i <= 1'b0;
   endtask
   task automatic pkt(input logic [2:0] code, input logic [23:0] b);
      logic [8:0] exp[$];
      logic [8:0] got[$];
      int n;
      int m;
      wr(MSP_IDX_CTRL, {5'h00, code, 8'h00});
      n = (code == MSP_PRE_ONE || code == MSP_PRE_TWO) && b[23:16] != 8'h55;
      if (n == 1 && code == MSP_PRE_TWO && b[15:8] != 8'h55) n = 2;
      for (int k = 0; k < n; k++) exp.push_back({k == 0, MSP_PRE_BYTE});
      for (int k = 0; k < 3; k++) begin
         exp.push_back({n == 0 && k == 0, b[23-8*k -: 8]});
      end
      msp_mac_model_i.got.delete();
      stall <= 1'b1;
      send3(b);
      repeat (30) @(posedge clk_i);
      got = msp_mac_model_i.got;
      m = got.size();
      cmp_word("beats", 16'(exp.size()), 16'(m));
      for (int k = 0; k < exp.size() && k < m; k++) begin
         cmp_word("beat", 16'(exp[k]), 16'(got[k]));
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {rst_b_i, soft_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, in_valid_i} = 6'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {media_link_i, stall} = 2'b10;
      pcs_stat_i = '0;
      in_beat_i = '0;
      int_adv_word_i = ADV_INT;
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset_page();
      t_outs(16'h2080);
      t_outs(16'h0060);
      t_media(16'hc000);
      t_media(16'h0000);
      t_link_negotiation();
      t_adv();
      t_status();
      t_soft();
      t_hard();
      pkt(MSP_PRE_NONE, 24'haabbcc);
      pkt(MSP_PRE_ONE, 24'haabbcc);
      pkt(MSP_PRE_ONE, 24'h55bbcc);
      pkt(MSP_PRE_TWO, 24'haabbcc);
      pkt(MSP_PRE_TWO, 24'haa55cc);
      pkt(MSP_PRE_TWO, 24'h55aacc);
      wr(MSP_IDX_PAGE, MSP_PAGE_RST);
      rdc("ctrl main page", MSP_IDX_CTRL, 16'h0000);
      results();
   end
   // The scenarios need well under a thousand cycles; this is ample.
   initial begin
      #(40 * 20000);
      miscompares++;
      results();
   end
endmodule
